// *** design/ecc_clutch.sv ***
// Cam clutch state machine with APB register access.
//
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/1ps

// How it works
// R01 - Enable cleared disables cam, forces disengage.
// R02 - Enable set lets Stop leave on engage.
// R03 - Three states, reset to Stop, no following.
// R04 - Engage condition: Stop to Lead, load initial.
// R05 - Lead Pulse: pulses only step counter.
// R06 - Counter target reached: Engaged, cam follows.
// R07 - Option four disengage: back to Lead, reengage.
// R08 - Options 1,2,6 or disable: Engaged to Stop.
// R09 - Disable in Lead returns to Stop.
// R10 - Selection zero engages once enabled.
// R11 - Selection one engages on clutch input.
// R12 - Selection two engages on capture, same cycle.
// R13 - Engage selection matters only in Stop.
// R14 - Forward master pulses decrement, reverse increment; zero means Engaged.
// R15 - Zero lead count engages without pulses.
// R16 - Setting sign picks counting pulse direction; the filtered master direction pin picks it instead.
// R17 - Lead counter value always readable.
// R18 - Counter overflow clears enable, forces Stop.
// R19 - Option one: input released leaves Engaged.
// R20 - Disable wins; one transition per cycle.
module ecc_clutch
    import ecc_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ECC_ADDR_W-1:0] paddr,
    input wire logic [ECC_DATA_W-1:0] pwdata,
    output logic [ECC_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Master axis pins.
    input wire logic master_step,
    input wire logic master_dir,
    // Clutch discrete input pin.
    input wire logic clutch_input,
    // Events from logic on this clock.
    input wire logic capture_event,
    input wire logic disengage_request,
    // Cam interpolator side.
    output logic cam_step,
    output logic cam_dir,
    output logic cam_engaged,
    output logic [1:0] clutch_state
);
    ecc_state_t state;
    ecc_state_t next_state;

    logic cam_enable_field;
    logic [1:0] engage_condition_select;
    logic [2:0] disengage_condition_select;
    logic signed [31:0] initial_lead_count;
    logic signed [31:0] reengage_lead_count;
    logic signed [31:0] disengage_count;
    logic overflow_seen;

    logic [ECC_SYNC_W-1:0] pin_level;
    logic step_prev;
    logic master_pulse;
    logic pulse_fwd;
    logic clutch_on;

    logic engage_hit;
    logic disengage_hit;
    logic next_lead_load;
    logic signed [31:0] next_lead_value;
    logic next_dis_load;

    logic apb_setup;
    logic apb_write;
    logic [ECC_DATA_W-1:0] read_word;

    ecc_cnt_if lead_if ();
    ecc_cnt_if dis_if ();

    ecc_sync u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .pin({clutch_input, master_dir, master_step}),
        .level(pin_level)
    );

    ecc_lead_counter u_lead_counter (
        .ref_clk(ref_clk),
        .rst(rst),
        .bus(lead_if.cnt)
    );

    ecc_lead_counter u_dis_counter (
        .ref_clk(ref_clk),
        .rst(rst),
        .bus(dis_if.cnt)
    );

    // A master pulse is the rising edge of the filtered step level.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            step_prev <= 1'b0;
        end else begin
            step_prev <= pin_level[ECC_PIN_STEP];
        end
    end

    assign master_pulse = pin_level[ECC_PIN_STEP] & ~step_prev;
    assign pulse_fwd = pin_level[ECC_PIN_DIR];
    assign clutch_on = pin_level[ECC_PIN_DI];

    // Engage condition, looked at only while stopped.
    always_comb begin
        case (engage_condition_select)
            ECC_ENG_IMMEDIATE: engage_hit = 1'b1; // R10
            ECC_ENG_DISCRETE: engage_hit = clutch_on; // R11
            ECC_ENG_CAPTURE: engage_hit = capture_event; // R12
            default: engage_hit = 1'b0;
        endcase
    end

    // Disengage condition while engaged.
    always_comb begin
        case (disengage_condition_select)
            ECC_DIS_DI_OFF: disengage_hit = ~clutch_on; // R19
            ECC_DIS_COUNT: disengage_hit = dis_if.zero;
            ECC_DIS_REENGAGE: disengage_hit = dis_if.zero;
            ECC_DIS_REQUEST: disengage_hit = disengage_request;
            default: disengage_hit = 1'b0;
        endcase
    end

    // Next state: disable and overflow outrank every other transition.
    always_comb begin
        next_state = state;
        next_lead_load = 1'b0;
        next_lead_value = initial_lead_count;
        next_dis_load = 1'b0;
        if (!cam_enable_field || lead_if.overflow) begin
            next_state = ECC_STOP; // R01 R09 R18 R20
        end else begin
            case (state)
                ECC_STOP: begin
                    if (engage_hit) begin // R02 R13
                        next_state = ECC_LEAD; // R04
                        next_lead_load = 1'b1;
                        next_lead_value = initial_lead_count;
                    end
                end
                ECC_LEAD: begin
                    if (lead_if.zero) begin // R14 R15
                        next_state = ECC_ENGAGED; // R06
                        next_dis_load = 1'b1;
                    end
                end
                ECC_ENGAGED: begin
                    if (disengage_hit) begin
                        if (disengage_condition_select == ECC_DIS_REENGAGE) begin
                            next_state = ECC_LEAD; // R07
                            next_lead_load = 1'b1;
                            next_lead_value = reengage_lead_count;
                        end else begin
                            next_state = ECC_STOP; // R08
                        end
                    end
                end
                default: next_state = ECC_STOP;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state <= ECC_STOP; // R03
        end else begin
            state <= next_state; // R20
        end
    end

    // Lead counter counts only in Lead Pulse; the filtered master direction pin picks the direction.
    assign lead_if.load = next_lead_load;
    assign lead_if.load_value = next_lead_value;
    assign lead_if.step = (state == ECC_LEAD) & master_pulse & ~next_lead_load; // R05 R14
    assign lead_if.step_fwd = pulse_fwd; // R16

    // Disengage counter counts master pulses while engaged.
    assign dis_if.load = next_dis_load;
    assign dis_if.load_value = disengage_count;
    assign dis_if.step = (state == ECC_ENGAGED) & master_pulse;
    assign dis_if.step_fwd = pulse_fwd;

    // The cam follows master pulses only while engaged.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cam_step <= 1'b0;
            cam_dir <= 1'b0;
            cam_engaged <= 1'b0;
            clutch_state <= ECC_STOP;
        end else begin
            cam_step <= (state == ECC_ENGAGED) & master_pulse; // R03 R06
            cam_dir <= pulse_fwd;
            cam_engaged <= (next_state == ECC_ENGAGED);
            clutch_state <= next_state;
        end
    end

    assign apb_setup = psel & ~penable;
    assign apb_write = psel & penable & pready & pwrite;

    // Control register; an overflow clears the enable even against a write.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cam_enable_field <= 1'b0;
            engage_condition_select <= ECC_ENG_IMMEDIATE;
            disengage_condition_select <= ECC_DIS_NONE;
        end else begin
            if (apb_write && paddr == ECC_CTRL_OFS) begin
                cam_enable_field <= pwdata[ECC_CTRL_EN_BIT];
                engage_condition_select <= pwdata[ECC_CTRL_ENG_LSB +: 2];
                disengage_condition_select <= pwdata[ECC_CTRL_DIS_LSB +: 3];
            end
            if (lead_if.overflow) begin
                cam_enable_field <= 1'b0; // R18
            end
        end
    end

    // Count settings.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            initial_lead_count <= ECC_REG_RST;
            reengage_lead_count <= ECC_REG_RST;
            disengage_count <= ECC_REG_RST;
        end else if (apb_write) begin
            if (paddr == ECC_INIT_LEAD_OFS) begin
                initial_lead_count <= pwdata;
            end
            if (paddr == ECC_REENG_LEAD_OFS) begin
                reengage_lead_count <= pwdata;
            end
            if (paddr == ECC_DIS_COUNT_OFS) begin
                disengage_count <= pwdata;
            end
        end
    end

    // Sticky overflow flag, cleared by writing one; a new overflow wins over the clear.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            overflow_seen <= 1'b0;
        end else if (lead_if.overflow) begin
            overflow_seen <= 1'b1;
        end else if (apb_write && paddr == ECC_STATUS_OFS && pwdata[ECC_STAT_OVF_BIT]) begin
            overflow_seen <= 1'b0;
        end
    end

    // Read multiplexer.
    always_comb begin
        read_word = ECC_REG_RST;
        case (paddr)
            ECC_CTRL_OFS: begin
                read_word[ECC_CTRL_EN_BIT] = cam_enable_field;
                read_word[ECC_CTRL_ENG_LSB +: 2] = engage_condition_select;
                read_word[ECC_CTRL_DIS_LSB +: 3] = disengage_condition_select;
            end
            ECC_INIT_LEAD_OFS: read_word = initial_lead_count;
            ECC_REENG_LEAD_OFS: read_word = reengage_lead_count;
            ECC_DIS_COUNT_OFS: read_word = disengage_count;
            ECC_STATUS_OFS: begin
                read_word[ECC_STAT_STATE_LSB +: 2] = state;
                read_word[ECC_STAT_DI_BIT] = clutch_on;
                read_word[ECC_STAT_OVF_BIT] = overflow_seen;
            end
            ECC_LEAD_MON_OFS: read_word = lead_if.value; // R17
            default: read_word = ECC_REG_RST;
        endcase
    end

    // Every access gets one wait-free access phase; data and error are set up in the setup cycle.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= ECC_REG_RST;
        end else begin
            pready <= apb_setup;
            pslverr <= apb_setup & ~ecc_mapped(paddr);
            if (apb_setup) begin
                prdata <= pwrite ? ECC_REG_RST : read_word;
            end
        end
    end
endmodule // ecc_clutch

// *** design/ecc_pkg.sv ***
// Constants, register map and state type of the cam clutch controller.
package ecc_pkg;

    localparam int unsigned ECC_DATA_W = 32;
    localparam int unsigned ECC_ADDR_W = 8;

    // Register byte offsets.
    localparam logic [7:0] ECC_CTRL_OFS = 8'h00;
    localparam logic [7:0] ECC_INIT_LEAD_OFS = 8'h04;
    localparam logic [7:0] ECC_REENG_LEAD_OFS = 8'h08;
    localparam logic [7:0] ECC_DIS_COUNT_OFS = 8'h0c;
    localparam logic [7:0] ECC_STATUS_OFS = 8'h10;
    localparam logic [7:0] ECC_LEAD_MON_OFS = 8'h14;

    // Control register fields.
    localparam int unsigned ECC_CTRL_EN_BIT = 0;
    localparam int unsigned ECC_CTRL_ENG_LSB = 4;
    localparam int unsigned ECC_CTRL_DIS_LSB = 8;

    // Status register fields.
    localparam int unsigned ECC_STAT_STATE_LSB = 0;
    localparam int unsigned ECC_STAT_DI_BIT = 4;
    localparam int unsigned ECC_STAT_OVF_BIT = 8;

    // Engage condition selections.
    localparam logic [1:0] ECC_ENG_IMMEDIATE = 2'h0;
    localparam logic [1:0] ECC_ENG_DISCRETE = 2'h1;
    localparam logic [1:0] ECC_ENG_CAPTURE = 2'h2;

    // Disengage condition selections.
    localparam logic [2:0] ECC_DIS_NONE = 3'h0;
    localparam logic [2:0] ECC_DIS_DI_OFF = 3'h1;
    localparam logic [2:0] ECC_DIS_COUNT = 3'h2;
    localparam logic [2:0] ECC_DIS_REENGAGE = 3'h4;
    localparam logic [2:0] ECC_DIS_REQUEST = 3'h6;

    // Reset values.
    localparam logic [31:0] ECC_REG_RST = 32'h0000_0000;
    localparam logic [2:0] ECC_SYNC_RST = 3'h0;

    // Lead counter limits.
    localparam logic signed [31:0] ECC_CNT_MIN = 32'sh8000_0000;
    localparam logic signed [31:0] ECC_CNT_MAX = 32'sh7fff_ffff;

    // Synchronised pin positions.
    localparam int unsigned ECC_SYNC_W = 3;
    localparam int unsigned ECC_PIN_STEP = 0;
    localparam int unsigned ECC_PIN_DIR = 1;
    localparam int unsigned ECC_PIN_DI = 2;

    typedef enum logic [1:0] {
        ECC_STOP = 2'b00,
        ECC_LEAD = 2'b01,
        ECC_ENGAGED = 2'b10
    } ecc_state_t;

    // True for every mapped register offset.
    function automatic logic ecc_mapped(input logic [7:0] addr);
        return (addr == ECC_CTRL_OFS) || (addr == ECC_INIT_LEAD_OFS) ||
               (addr == ECC_REENG_LEAD_OFS) || (addr == ECC_DIS_COUNT_OFS) ||
               (addr == ECC_STATUS_OFS) || (addr == ECC_LEAD_MON_OFS);
    endfunction

endpackage

// *** design/ecc_cnt_if.sv ***
// Link between the clutch controller and one signed pulse counter.
`timescale 1ns/1ps
interface ecc_cnt_if;
    logic load;
    logic signed [31:0] load_value;
    logic step;
    logic step_fwd;
    logic signed [31:0] value;
    logic zero;
    logic overflow;

    modport ctl (
        output load,
        output load_value,
        output step,
        output step_fwd,
        input value,
        input zero,
        input overflow
    );

    modport cnt (
        input load,
        input load_value,
        input step,
        input step_fwd,
        output value,
        output zero,
        output overflow
    );
endinterface

// *** design/ecc_sync.sv ***
// Three-stage pin synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
module ecc_sync
    import ecc_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst,
    // Pins and filtered levels.
    input wire logic [ECC_SYNC_W-1:0] pin,
    output logic [ECC_SYNC_W-1:0] level
);
    logic [ECC_SYNC_W-1:0] stage1;
    logic [ECC_SYNC_W-1:0] stage2;
    logic [ECC_SYNC_W-1:0] stage3;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            stage1 <= ECC_SYNC_RST;
            stage2 <= ECC_SYNC_RST;
            stage3 <= ECC_SYNC_RST;
        end else begin
            stage1 <= pin;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // Each bit follows only when the last two stages agree.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            level <= ECC_SYNC_RST;
        end else begin
            level <= (stage2 & stage3) | (level & (stage2 | stage3));
        end
    end
endmodule // ecc_sync

// *** design/ecc_lead_counter.sv ***
// Signed pulse up/down counter whose count direction follows the pulse direction.
`timescale 1ns/1ps
module ecc_lead_counter
    import ecc_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst,
    // Controller side.
    ecc_cnt_if.cnt bus
);
    logic signed [31:0] count;
    logic ovf;

    // Forward pulses move the count down, reverse pulses move it up.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            count <= ECC_REG_RST;
            ovf <= 1'b0;
        end else begin
            ovf <= 1'b0;
            if (bus.load) begin
                count <= bus.load_value;
            end else if (bus.step) begin
                if (bus.step_fwd) begin
                    if (count == ECC_CNT_MIN) begin
                        ovf <= 1'b1;
                    end else begin
                        count <= count - 32'sh0000_0001;
                    end
                end else begin
                    if (count == ECC_CNT_MAX) begin
                        ovf <= 1'b1;
                    end else begin
                        count <= count + 32'sh0000_0001;
                    end
                end
            end
        end
    end

    assign bus.value = count;
    assign bus.zero = (count == 32'sh0000_0000);
    assign bus.overflow = ovf;
endmodule // ecc_lead_counter

// *** bench/ecc_clutch_props.sv ***
// Concurrent checks on the cam clutch controller ports.
`timescale 1ns/1ps
module ecc_clutch_props
    import ecc_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ECC_ADDR_W-1:0] paddr,
    input wire logic [ECC_DATA_W-1:0] pwdata,
    input wire logic [ECC_DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pins and events.
    input wire logic master_step,
    input wire logic master_dir,
    input wire logic clutch_input,
    input wire logic capture_event,
    input wire logic disengage_request,
    // Cam side.
    input wire logic cam_step,
    input wire logic cam_dir,
    input wire logic cam_engaged,
    input wire logic [1:0] clutch_state
);
    logic en_q;
    logic [1:0] sel_q;
    logic [2:0] dis_q;
    wire ctrl_wr = psel && penable && pready && pwrite && paddr == ECC_CTRL_OFS;

    // Shadow of the control fields as software last wrote them.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            en_q <= 1'b0;
            sel_q <= 2'h0;
            dis_q <= 3'h0;
        end else if (ctrl_wr) begin
            en_q <= pwdata[0];
            sel_q <= pwdata[5:4];
            dis_q <= pwdata[10:8];
        end
    end

    default clocking dc @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    a_state_legal: assert property (clutch_state != 2'b11)
        else $error("Clutch state code out of range.");
    a_engaged_flag: assert property (cam_engaged == (clutch_state == ECC_ENGAGED))
        else $error("Engaged flag disagrees with state.");
    a_no_follow: assert property (cam_step |-> $past(clutch_state) == ECC_ENGAGED)
        else $error("Cam stepped outside Engaged.");
    a_apb_answer: assert property (psel && !penable |=> pready)
        else $error("No answer in the access cycle.");
    a_slverr_map: assert property (pready |-> pslverr == (paddr > 8'h14 || paddr[1:0] != 2'b00))
        else $error("Error flag disagrees with address map.");
    a_stop_exit: assert property (clutch_state == ECC_STOP |=> clutch_state != ECC_ENGAGED)
        else $error("Stop jumped straight to Engaged.");
    a_off_stop: assert property (!en_q && !$past(en_q) |-> clutch_state == ECC_STOP)
        else $error("Disabled clutch left Stop.");
    a_imm_engage: assert property (ctrl_wr && !en_q && pwdata[0] && pwdata[5:4] == 2'h0
        |-> ##2 clutch_state == ECC_LEAD)
        else $error("Immediate engage did not reach Lead.");
    a_capture: assert property (clutch_state == ECC_STOP && en_q && sel_q == ECC_ENG_CAPTURE && capture_event
        |=> clutch_state == ECC_LEAD)
        else $error("Capture did not engage at once.");
    a_request_stop: assert property (clutch_state == ECC_ENGAGED && en_q && dis_q == ECC_DIS_REQUEST
        && disengage_request |=> clutch_state == ECC_STOP)
        else $error("Disengage request did not stop the cam.");
endmodule // ecc_clutch_props

// *** bench/ecc_axis_model.sv ***
// Master axis pulse source and cam step counter for the clutch bench.
`timescale 1ns/1ps
module ecc_axis_model (
    // Clock.
    input wire logic ref_clk,
    // Master axis pins.
    output logic master_step,
    output logic master_dir,
    // Cam side.
    input wire logic cam_step
);
    int cam_pulses = 0;

    initial begin
        master_step = 1'b0;
        master_dir = 1'b1;
    end

    always @(posedge ref_clk) begin
        if (cam_step === 1'b1) begin
            cam_pulses <= cam_pulses + 1;
        end
    end

    // Levels are held five cycles so the pin filter sees every edge.
    task automatic pulses(input int n, input logic fwd);
        @(posedge ref_clk);
        master_dir <= fwd;
        repeat (5) @(posedge ref_clk);
        repeat (n) begin
            master_step <= 1'b1;
            repeat (5) @(posedge ref_clk);
            master_step <= 1'b0;
            repeat (5) @(posedge ref_clk);
        end
    endtask
endmodule // ecc_axis_model

// *** bench/ecc_clutch_tb.sv ***
// Self-checking bench for the cam clutch controller.
`timescale 1ns/1ps
module ecc_clutch_tb
    import ecc_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, master_step, master_dir, cam_step, cam_dir, cam_engaged;
    logic clutch_input = 1'b0;
    logic capture_event = 1'b0;
    logic disengage_request = 1'b0;
    logic [1:0] clutch_state;
    int n_errors = 0;
    int checked = 0;

    ecc_clutch dut (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .master_step, .master_dir, .clutch_input, .capture_event, .disengage_request, .cam_step, .cam_dir,
        .cam_engaged, .clutch_state);
    ecc_axis_model model (.ref_clk, .master_step, .master_dir, .cam_step);

    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic summarize();
        $display("Mismatches %0d of %0d comparisons.", n_errors, checked);
        if (n_errors == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] act, input logic [31:0] exp);
        checked++;
        if (act !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, act, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
        output logic err);
        int i;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge ref_clk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (i >= 20) begin
            n_errors++;
            summarize();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        chk(r, exp);
    endtask

    task automatic wait_st(input logic [1:0] s);
        int i;
        for (i = 0; i < 60 && clutch_state !== s; i++) @(posedge ref_clk);
        chk(32'(clutch_state), 32'(s));
        if (clutch_state !== s) summarize();
    endtask

    task automatic t_reset();
        logic [31:0] r;
        logic e;
        for (int k = 0; k < 6; k++) rd_chk(8'(4 * k), 32'h0000_0000);
        apb(1'b0, 8'h20, 32'h0000_0000, r, e);
        chk(32'(e), 32'h0000_0001);
        wr(ECC_LEAD_MON_OFS, 32'h0000_0005);
        rd_chk(ECC_LEAD_MON_OFS, 32'h0000_0000);
    endtask

    task automatic t_lead();
        int c0;
        wr(ECC_INIT_LEAD_OFS, 32'h0000_0003);
        wr(ECC_CTRL_OFS, 32'h0000_0001);
        wait_st(ECC_LEAD);
        rd_chk(ECC_LEAD_MON_OFS, 32'h0000_0003);
        model.pulses(2, 1'b1);
        rd_chk(ECC_LEAD_MON_OFS, 32'h0000_0001);
        chk(32'(clutch_state), 32'(ECC_LEAD));
        chk(model.cam_pulses, 32'h0000_0000);
        model.pulses(1, 1'b1);
        wait_st(ECC_ENGAGED);
        chk(32'(cam_engaged), 32'h0000_0001);
        c0 = model.cam_pulses;
        model.pulses(3, 1'b1);
        chk(model.cam_pulses - c0, 32'h0000_0003);
        chk(32'(cam_dir), 32'h0000_0001);
        wr(ECC_CTRL_OFS, 32'h0000_0000);
        wait_st(ECC_STOP);
        chk(32'(cam_engaged), 32'h0000_0000);
    endtask

    task automatic t_reverse();
        wr(ECC_INIT_LEAD_OFS, 32'hffff_fffe);
        wr(ECC_CTRL_OFS, 32'h0000_0001);
        wait_st(ECC_LEAD);
        model.pulses(2, 1'b0);
        wait_st(ECC_ENGAGED);
        chk(32'(cam_dir), 32'h0000_0000);
        wr(ECC_INIT_LEAD_OFS, 32'h0000_0005);
        wr(ECC_CTRL_OFS, 32'h0000_0000);
        wait_st(ECC_STOP);
        wr(ECC_CTRL_OFS, 32'h0000_0001);
        wait_st(ECC_LEAD);
        wr(ECC_CTRL_OFS, 32'h0000_0000);
        wait_st(ECC_STOP);
    endtask

    task automatic t_zero_request();
        int c0;
        c0 = model.cam_pulses;
        wr(ECC_INIT_LEAD_OFS, 32'h0000_0000);
        wr(ECC_CTRL_OFS, 32'h0000_0601);
        wait_st(ECC_ENGAGED);
        chk(model.cam_pulses - c0, 32'h0000_0000);
        @(posedge ref_clk);
        disengage_request <= 1'b1;
        @(posedge ref_clk);
        disengage_request <= 1'b0;
        wait_st(ECC_STOP);
    endtask

    task automatic t_input();
        wr(ECC_CTRL_OFS, 32'h0000_0111);
        repeat (10) @(posedge ref_clk);
        chk(32'(clutch_state), 32'(ECC_STOP));
        clutch_input <= 1'b1;
        wait_st(ECC_ENGAGED);
        clutch_input <= 1'b0;
        wait_st(ECC_STOP);
    endtask

    task automatic t_capture();
        wr(ECC_CTRL_OFS, 32'h0000_0021);
        repeat (10) @(posedge ref_clk);
        chk(32'(clutch_state), 32'(ECC_STOP));
        capture_event <= 1'b1;
        @(posedge ref_clk);
        capture_event <= 1'b0;
        @(posedge ref_clk);
        chk(32'(clutch_state), 32'(ECC_LEAD));
        wr(ECC_CTRL_OFS, 32'h0000_0000);
        wait_st(ECC_STOP);
    endtask

    task automatic t_reengage();
        wr(ECC_DIS_COUNT_OFS, 32'h0000_0002);
        wr(ECC_REENG_LEAD_OFS, 32'h0000_0001);
        wr(ECC_CTRL_OFS, 32'h0000_0401);
        wait_st(ECC_ENGAGED);
        model.pulses(2, 1'b1);
        wait_st(ECC_LEAD);
        rd_chk(ECC_LEAD_MON_OFS, 32'h0000_0001);
        model.pulses(1, 1'b1);
        wait_st(ECC_ENGAGED);
        wr(ECC_CTRL_OFS, 32'h0000_0000);
        wait_st(ECC_STOP);
        wr(ECC_DIS_COUNT_OFS, 32'h0000_0001);
        wr(ECC_CTRL_OFS, 32'h0000_0201);
        wait_st(ECC_ENGAGED);
        // Capture select keeps the clutch in Stop after the count runs out.
        wr(ECC_CTRL_OFS, 32'h0000_0221);
        chk(32'(clutch_state), 32'(ECC_ENGAGED));
        model.pulses(1, 1'b1);
        wait_st(ECC_STOP);
    endtask

    task automatic t_overflow();
        wr(ECC_INIT_LEAD_OFS, 32'h7fff_ffff);
        wr(ECC_CTRL_OFS, 32'h0000_0001);
        wait_st(ECC_LEAD);
        model.pulses(1, 1'b0);
        wait_st(ECC_STOP);
        rd_chk(ECC_CTRL_OFS, 32'h0000_0000);
        rd_chk(ECC_STATUS_OFS, 32'h0000_0100);
        rd_chk(ECC_LEAD_MON_OFS, 32'h7fff_ffff);
        wr(ECC_STATUS_OFS, 32'h0000_0100);
        rd_chk(ECC_STATUS_OFS, 32'h0000_0000);
    endtask

    initial begin
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset();
        t_lead();
        t_reverse();
        t_zero_request();
        t_input();
        t_capture();
        t_reengage();
        t_overflow();
        summarize();
    end
endmodule // ecc_clutch_tb

bind ecc_clutch ecc_clutch_props u_props (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .master_step, .master_dir, .clutch_input, .capture_event, .disengage_request,
    .cam_step, .cam_dir, .cam_engaged, .clutch_state);
